// ===== core/ccs_pkg.sv
// Package with register map, field positions and encodings of the shutdown/steering block
package ccs_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_GATE_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_PWM_CFG    = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  // Reset values
  localparam logic [31:0] RST_GATE_CTRL  = 32'h0100_0000;
  localparam logic [31:0] RST_PWM_CFG    = 32'h0000_0000;
  // Writable masks
  localparam logic [31:0] MASK_GATE_CTRL = 32'hbfdf_d0ff;
  localparam logic [31:0] MASK_PWM_CFG   = 32'hf73f_003f;
  // Gate control field positions
  localparam int GC_OE_SYNC    = 31;
  localparam int GC_STEER_LO   = 24;
  localparam int GC_GMODE_LO   = 22;
  localparam int GC_AUX_LO     = 19;
  localparam int GC_CSRC_LO    = 16;
  localparam int GC_RESTART    = 15;
  localparam int GC_SD_GATE    = 14;
  localparam int GC_SW_SD      = 12;
  localparam int GC_SRC_LO     = 0;
  // Output config field positions
  localparam int PC_WAIT_TRIG  = 31;
  localparam int PC_OS_LO      = 28;
  localparam int PC_MODE_LO    = 24;
  localparam int PC_POL1       = 21;
  localparam int PC_POL2       = 20;
  localparam int PC_SS1_LO     = 18;
  localparam int PC_SS2_LO     = 16;
  localparam int PC_DT_LO      = 0;
  // Status bit positions
  localparam int ST_GATE_ARM   = 10;
  localparam int ST_TRIG       = 7;
  localparam int ST_TSET       = 6;
  localparam int ST_TCLR       = 5;
  localparam int ST_SD         = 4;
  localparam int ST_CMP        = 3;
  localparam int ST_CDIS       = 2;
  localparam int ST_COV        = 1;
  localparam int ST_CBNE       = 0;
  // Capture gate modes
  typedef enum logic [1:0] {
    CCS_GATE_LEVEL = 2'b00,
    CCS_GATE_RISE  = 2'b01,
    CCS_GATE_FALL  = 2'b10,
    CCS_GATE_RSVD  = 2'b11
  } ccs_gate_t;
  // Output modes
  localparam logic [2:0] OM_STEER   = 3'h0;
  localparam logic [2:0] OM_PUSH    = 3'h1;
  localparam logic [2:0] OM_HALF    = 3'h2;
  localparam logic [2:0] OM_BDC_REV = 3'h4;
  localparam logic [2:0] OM_BDC_FWD = 3'h5;
  localparam logic [2:0] OM_SCAN    = 3'h6;
  // Aux event selects
  localparam logic [1:0] AUX_OFF    = 2'h0;
  localparam logic [1:0] AUX_ROLL   = 2'h1;
  localparam logic [1:0] AUX_MODE   = 2'h2;
  localparam logic [1:0] AUX_EVENT  = 2'h3;
endpackage : ccs_pkg

// ===== core/ccs_pin_if.sv
// Interface carrying pin-stage control from the top to the pin driver
`timescale 1ns/10ps
interface ccs_pin_if;
  logic [5:0] enables;    // Steering enables in effect
  logic [5:0] raw;        // Active-high pin drive before polarity
  logic       pol1;       // Group A/C/E active low
  logic       pol2;       // Group B/D/F active low
  logic [1:0] ss1;        // Shutdown state group A/C/E
  logic [1:0] ss2;        // Shutdown state group B/D/F
  logic       shut;       // Shutdown in force
  logic       hold;       // Waiting for trigger, do not drive
  logic [5:0] dead_time;  // Dead-time count
  modport ctrl (output enables, raw, pol1, pol2, ss1, ss2, shut, hold,
                dead_time);
  modport drv  (input enables, raw, pol1, pol2, ss1, ss2, shut, hold,
                dead_time);
endinterface : ccs_pin_if

// ===== core/ccs_pin_drive.sv
// Pin driver: dead time, polarity and shutdown states per output
`timescale 1ns/10ps
module ccs_pin_drive (
  input  wire logic       pclk,     // Clock
  input  wire logic       presetn,  // Async reset, active low
  ccs_pin_if.drv          pin,      // Control from the top
  output logic      [5:0] pin_o,    // Pin levels
  output logic      [5:0] pin_oen   // Pin enables, low drives
);
  logic [5:0] dt_cnt [0:5];
  logic [5:0] gated;
  logic [5:0] level;
  logic [5:0] en_n;
  logic [5:0] pol_vec;
  logic [5:0] act_vec;
  logic [5:0] ss_drive;

  assign pol_vec = {3{pin.pol2, pin.pol1}};

  // Rising edges held low for dead time; zero count bypasses delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int i = 0; i < 6; i++)
      if (!presetn)
        dt_cnt[i] <= 6'h00;
      else if (!pin.raw[i] || pin.dead_time == 6'h00)
        dt_cnt[i] <= 6'h00;
      else if (dt_cnt[i] != pin.dead_time)
        dt_cnt[i] <= dt_cnt[i] + 6'h01;
  end

  // Dead time applied before polarity so inactive level follows it
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      gated[i]    = pin.raw[i] && (pin.dead_time == 6'h00 ||
                    dt_cnt[i] == pin.dead_time);
      act_vec[i]  = (i % 2 == 0) ? pin.ss1[0] : pin.ss2[0];
      ss_drive[i] = (i % 2 == 0) ? pin.ss1[1] : pin.ss2[1];
      level[i]    = (pin.shut ? act_vec[i] : gated[i]) ^ pol_vec[i];
      en_n[i]     = !pin.enables[i] || pin.hold ||
                    (pin.shut && !ss_drive[i]);
    end
  end

  // Registered pin stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_o   <= 6'h00;
      pin_oen <= 6'h3f;
    end
    else
    begin
      pin_o   <= level;
      pin_oen <= en_n;
    end
  end
endmodule : ccs_pin_drive

// ===== core/ccs_sync2.sv
// Two-flop synchroniser for a bus of external levels
`timescale 1ns/10ps
module ccs_sync2 #(
  parameter int W = 8
) (
  input  wire logic         pclk,    // Clock
  input  wire logic         presetn, // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output logic      [W-1:0] q        // Synchronised outputs
);
  logic [W-1:0] meta;
  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : ccs_sync2

// ===== core/ccs_ctrl.sv
// Top: APB registers, shutdown, gating, trigger and steering control
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module ccs_ctrl (
  input  wire logic        pclk,         // Clock
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  input  wire logic        triggered_mode_enable, // Triggered operation
  input  wire logic        single_shot_enable,    // One-shot trigger
  input  wire logic        tb_rollover,  // Time base reset/rollover pulse
  input  wire logic        tb_tick,      // Timer count period pulse
  input  wire logic        hw_trigger,   // Hardware trigger pulse
  input  wire logic        timer_mode,   // Module in timer mode
  input  wire logic        mode_signal,  // Mode-dependent aux signal
  input  wire logic        cc_event,     // Capture/compare event pulse
  input  wire logic        cmp_event,    // Single-edge compare event
  input  wire logic        cap_overflow, // Capture buffer overflow pulse
  input  wire logic        cap_not_empty,// Capture buffer has data
  input  wire logic [5:0]  pwm_raw,      // Active-high PWM per pin
  input  wire logic        capture_input_pin, // External capture pin
  input  wire logic [2:0]  comparators,  // Comparator 3..1 outputs
  input  wire logic [3:0]  logic_cells,  // Logic cell 4..1 outputs
  input  wire logic        fault_pin_a,  // External fault pin A
  input  wire logic        fault_pin_b,  // External fault pin B
  input  wire logic [1:0]  timer_outs,   // Other timer module outputs
  output logic      [5:0]  pin_o,        // Output pin levels
  output logic      [5:0]  pin_oen,      // Pin enables, low drives
  output logic             aux_out,      // Auxiliary event output
  output logic             capture_src,  // Selected capture source
  output logic             capture_event,// Capture allowed event
  output logic             timer_hold,   // Timer held in reset
  output logic      [2:0]  out_mode      // Active output mode
);
  logic [31:0] gate_ctrl;
  logic [31:0] pwm_cfg;
  logic [5:0]  steer;
  logic        trig;
  logic        sd_flag;
  logic        cmp_flag;
  logic        cdis;
  logic        cov_flag;
  logic        armed;
  logic        src_q;
  logic        sd_pend;
  logic [2:0]  os_cnt;
  logic [11:0] ext_s;
  logic [11:0] ext_raw;

  ccs_pin_if pin ();

  // External pins sampled twice before use
  assign ext_raw = {fault_pin_b, fault_pin_a, logic_cells, timer_outs,
                    comparators, capture_input_pin};
  ccs_sync2 #(.W(12)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (ext_raw),
    .q       (ext_s)
  );

  // APB decode
  wire        wr_en   = psel && penable && pwrite;
  wire        hit_gc  = paddr == ccs_pkg::ADDR_GATE_CTRL;
  wire        hit_pc  = paddr == ccs_pkg::ADDR_PWM_CFG;
  wire        hit_st  = paddr == ccs_pkg::ADDR_STATUS;
  wire        mapped  = hit_gc || hit_pc || hit_st;
  wire        wr_st   = wr_en && hit_st;

  // Field views
  wire        oe_sync  = gate_ctrl[ccs_pkg::GC_OE_SYNC];
  wire [5:0]  steer_wr = gate_ctrl[ccs_pkg::GC_STEER_LO +: 6];
  wire [1:0]  gmode    = gate_ctrl[ccs_pkg::GC_GMODE_LO +: 2];
  wire [1:0]  aux_sel  = gate_ctrl[ccs_pkg::GC_AUX_LO +: 2];
  wire [2:0]  csrc_sel = gate_ctrl[ccs_pkg::GC_CSRC_LO +: 3];
  wire        restart  = gate_ctrl[ccs_pkg::GC_RESTART];
  wire        sd_gate  = gate_ctrl[ccs_pkg::GC_SD_GATE];
  wire        sw_sd    = gate_ctrl[ccs_pkg::GC_SW_SD];
  wire [7:0]  src_en   = gate_ctrl[ccs_pkg::GC_SRC_LO +: 8];
  wire        wait_trg = pwm_cfg[ccs_pkg::PC_WAIT_TRIG];
  wire [2:0]  os_len   = pwm_cfg[ccs_pkg::PC_OS_LO +: 3];
  wire [2:0]  mode_sel = pwm_cfg[ccs_pkg::PC_MODE_LO +: 3];

  // Shutdown sources from bit 7 down
  wire [7:0]  sd_srcs  = {ext_s[11:10], ext_s[6], ext_s[5:4],
                          ext_s[3:1]};
  wire        sd_req   = |(sd_srcs & src_en) || sw_sd;
  wire        sd_go    = sd_req && (!sd_gate || tb_rollover);

  // Capture source and gating
  wire [7:0]  csrc_vec = {ext_s[9:6], ext_s[3:1], ext_s[0]};
  wire        csrc     = csrc_vec[csrc_sel];
  wire        c_rise   = csrc && !src_q;
  wire        c_fall   = !csrc && src_q;
  wire        gm_set   = armed && gmode == ccs_pkg::CCS_GATE_FALL && c_fall;
  wire        gm_clr   = armed && gmode == ccs_pkg::CCS_GATE_RISE && c_rise;
  wire        cap_ok   = (gmode == ccs_pkg::CCS_GATE_LEVEL) ? csrc
                         : !cdis;

  // Status strobes, triggered mode only
  wire        tset     = wr_st && pwdata[ccs_pkg::ST_TSET] &&
                         triggered_mode_enable;
  wire        tclr     = wr_st && pwdata[ccs_pkg::ST_TCLR] &&
                         triggered_mode_enable;
  wire        os_done  = single_shot_enable && tb_tick &&
                         os_cnt == os_len;

  // Aux output select
  wire        aux_nxt  = (aux_sel == ccs_pkg::AUX_ROLL) ? tb_rollover :
                         (aux_sel == ccs_pkg::AUX_MODE) ? mode_signal :
                         (aux_sel == ccs_pkg::AUX_EVENT) ?
                         (cc_event && !timer_mode) : 1'b0;

  // Read mux; strobes and gate arm read zero
  wire [31:0] st_rd    = {24'h0, trig, 2'b00, sd_flag, cmp_flag, cdis,
                          cov_flag, cap_not_empty};
  wire [31:0] rd_mux   = hit_gc ? gate_ctrl : hit_pc ? pwm_cfg :
                         hit_st ? st_rd : 32'h0;

  // APB slave: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= rd_mux;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_ctrl <= ccs_pkg::RST_GATE_CTRL;
      pwm_cfg   <= ccs_pkg::RST_PWM_CFG;
    end
    else
    begin
      if (wr_en && hit_gc)
        gate_ctrl <= pwdata & ccs_pkg::MASK_GATE_CTRL;
      if (wr_en && hit_pc)
        pwm_cfg <= pwdata & ccs_pkg::MASK_PWM_CFG;
    end
  end

  // Steering enables, optionally deferred to rollover
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      steer <= ccs_pkg::RST_GATE_CTRL[ccs_pkg::GC_STEER_LO +: 6];
    else if (!oe_sync || tb_rollover)
      steer <= steer_wr;
  end

  // Shutdown flag; hardware set beats software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sd_flag <= 1'b0;
    else if (sd_go)
      sd_flag <= 1'b1;
    else if (restart && !sd_req && tb_rollover)
      sd_flag <= 1'b0;
    else if (wr_st && !pwdata[ccs_pkg::ST_SD])
      sd_flag <= 1'b0;
  end

  // Compare and overflow flags, write zero clears, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_flag <= 1'b0;
      cov_flag <= 1'b0;
    end
    else
    begin
      if (cmp_event)
        cmp_flag <= 1'b1;
      else if (wr_st && !pwdata[ccs_pkg::ST_CMP])
        cmp_flag <= 1'b0;
      if (cap_overflow)
        cov_flag <= 1'b1;
      else if (wr_st && !pwdata[ccs_pkg::ST_COV])
        cov_flag <= 1'b0;
    end
  end

  // Capture gating; armed by write, consumed by the one-shot edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cdis  <= 1'b0;
      armed <= 1'b0;
      src_q <= 1'b0;
    end
    else
    begin
      src_q <= csrc;
      if (gmode == ccs_pkg::CCS_GATE_LEVEL)
        cdis <= !csrc;
      else if (gm_set || (sw_sd && sd_go))
        cdis <= 1'b1;
      else if (gm_clr)
        cdis <= 1'b0;
      else if (wr_st && !pwdata[ccs_pkg::ST_CDIS])
        cdis <= 1'b0;
      if (wr_st && pwdata[ccs_pkg::ST_GATE_ARM])
        armed <= 1'b1;
      else if (gm_set || gm_clr)
        armed <= 1'b0;
    end
  end

  // Trigger status and one-shot length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig   <= 1'b0;
      os_cnt <= 3'h0;
    end
    else
    begin
      if (!triggered_mode_enable)
        trig <= 1'b0;
      else if (hw_trigger || tset)
        trig <= 1'b1;
      else if (tclr || os_done)
        trig <= 1'b0;
      if (!trig)
        os_cnt <= 3'h0;
      else if (tb_tick && os_cnt != os_len)
        os_cnt <= os_cnt + 3'h1;
    end
  end

  // Pin stage control
  assign pin.enables   = steer;
  assign pin.raw       = pwm_raw;
  assign pin.pol1      = pwm_cfg[ccs_pkg::PC_POL1];
  assign pin.pol2      = pwm_cfg[ccs_pkg::PC_POL2];
  assign pin.ss1       = pwm_cfg[ccs_pkg::PC_SS1_LO +: 2];
  assign pin.ss2       = pwm_cfg[ccs_pkg::PC_SS2_LO +: 2];
  assign pin.shut      = sd_flag;
  assign pin.hold      = triggered_mode_enable && wait_trg && !trig;
  assign pin.dead_time = pwm_cfg[ccs_pkg::PC_DT_LO +: 6];

  ccs_pin_drive u_drive (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (pin),
    .pin_o   (pin_o),
    .pin_oen (pin_oen)
  );

  // Registered side outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_out       <= 1'b0;
      capture_src   <= 1'b0;
      capture_event <= 1'b0;
      timer_hold    <= 1'b0;
      out_mode      <= ccs_pkg::OM_STEER;
    end
    else
    begin
      aux_out       <= aux_nxt;
      capture_src   <= csrc;
      capture_event <= c_rise && cap_ok;
      timer_hold    <= triggered_mode_enable && !trig;
      out_mode      <= mode_sel;
    end
  end
endmodule : ccs_ctrl

// ===== testbench/ccs_ctrl_chk.sv
// Concurrent checks on the control block's APB, pin and select ports
`timescale 1ns/10ps
module ccs_ctrl_chk (
  input wire logic        pclk,              // Clock
  input wire logic        presetn,           // Async reset, active low
  input wire logic        psel,              // APB select
  input wire logic        penable,           // APB enable
  input wire logic        pwrite,            // APB direction
  input wire logic [7:0]  paddr,             // APB address
  input wire logic [31:0] pwdata,            // APB write data
  input wire logic [31:0] prdata,            // APB read data
  input wire logic        pready,            // APB ready
  input wire logic        pslverr,           // APB error
  input wire logic        tb_rollover,       // Rollover pulse
  input wire logic        capture_input_pin, // Capture pin
  input wire logic [5:0]  pin_oen,           // Pin enables
  input wire logic        aux_out,           // Aux output
  input wire logic        capture_src,       // Selected source
  input wire logic        capture_event,     // Capture pulse
  input wire logic [2:0]  out_mode           // Output mode
);
  logic [31:0] gc_q; // Shadow of gate control
  logic [31:0] pc_q; // Shadow of output config
  logic        wr_en;
  logic        rd_en;
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && pready && !pwrite;
  // Shadows follow completed writes, masked like the real registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gc_q <= ccs_pkg::RST_GATE_CTRL;
      pc_q <= ccs_pkg::RST_PWM_CFG;
    end
    else if (wr_en && paddr == ccs_pkg::ADDR_GATE_CTRL)
      gc_q <= pwdata & ccs_pkg::MASK_GATE_CTRL;
    else if (wr_en && paddr == ccs_pkg::ADDR_PWM_CFG)
      pc_q <= pwdata & ccs_pkg::MASK_PWM_CFG;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_roll; gc_q[20:19] == ccs_pkg::AUX_ROLL && tb_rollover; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_strb;
    rd_en && paddr == ccs_pkg::ADDR_STATUS |->
      !prdata[10] && !prdata[6] && !prdata[5];
  endproperty
  property p_gc; rd_en && paddr == 8'h00 |-> prdata == gc_q; endproperty
  property p_pc; rd_en && paddr == 8'h04 |-> prdata == pc_q; endproperty
  property p_aux_off; (gc_q[20:19] == 2'h0) [*2] |-> !aux_out; endproperty
  property p_aux_roll; s_roll |-> ##[1:2] aux_out; endproperty
  property p_oen_off;
    (gc_q[29:24] == 6'h0 && !gc_q[31]) [*3] |-> pin_oen == 6'h3f;
  endproperty
  property p_csrc;
    (gc_q[18:16] == 3'h0 && capture_input_pin) [*5] |-> capture_src;
  endproperty
  property p_mode; $stable(pc_q) [*2] |-> out_mode == pc_q[26:24]; endproperty
  property p_cev;
    $past(gc_q[23:22]) == 2'h0 |-> capture_event == $rose(capture_src);
  endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  a_one: assert property (p_one) else $error("pready too long");
  a_err: assert property (p_err) else $error("bad error answer");
  a_strb: assert property (p_strb) else $error("strobe bit read one");
  a_gc: assert property (p_gc) else $error("gate control readback");
  a_pc: assert property (p_pc) else $error("output config readback");
  a_aux_off: assert property (p_aux_off) else $error("aux while off");
  a_aux_roll: assert property (p_aux_roll) else $error("aux missed");
  a_oen_off: assert property (p_oen_off) else $error("pin driven");
  a_csrc: assert property (p_csrc) else $error("capture pin lost");
  a_mode: assert property (p_mode) else $error("out_mode stale");
  a_cev: assert property (p_cev) else $error("capture event wrong");
endmodule : ccs_ctrl_chk

bind ccs_ctrl ccs_ctrl_chk chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tb_rollover(tb_rollover), .capture_input_pin(capture_input_pin),
  .pin_oen(pin_oen), .aux_out(aux_out), .capture_src(capture_src),
  .capture_event(capture_event), .out_mode(out_mode));

// ===== testbench/ccs_far_model.sv
// Far side: fault, comparator, cell and capture drivers, pin load
`timescale 1ns/10ps
module ccs_far_model (
  input  wire logic [7:0] sd_src,      // Sources in enable bit order
  input  wire logic [7:0] cap_src,     // Sources in select code order
  input  wire logic [5:0] pin_o,       // Pin levels
  input  wire logic [5:0] pin_oen,     // Pin enables, low drives
  output logic            fault_pin_a, // Fault A
  output logic            fault_pin_b, // Fault B
  output logic      [1:0] timer_outs,  // Other timer outputs
  output logic      [2:0] comparators, // Comparators 3..1
  output logic      [3:0] logic_cells, // Cells 4..1
  output logic            cap_pin,     // Capture pin
  output logic      [5:0] pin_lvl      // Level at the power stage
);
  // Shared lines carry either view; tests never use both at once
  assign fault_pin_b = sd_src[7];
  assign fault_pin_a = sd_src[6];
  assign timer_outs  = sd_src[4:3];
  assign comparators = sd_src[2:0] | cap_src[3:1];
  assign logic_cells = cap_src[7:4] | {3'h0, sd_src[5]};
  assign cap_pin     = cap_src[0];
  // Released pins are pulled down by the gate drivers
  assign pin_lvl = pin_o & ~pin_oen;
endmodule : ccs_far_model

// ===== testbench/tb_top.sv
// Self-checking bench for the shutdown and steering control block
`timescale 1ns/10ps
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic        trig_en, one_en, tick, hw_trig, tmode, msig, not_empty;
  logic        fa, fb, cpin, aux_out, capture_src, capture_event, timer_hold;
  logic [7:0]  paddr, sd_src, cap_src;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pv, cells;
  logic [5:0]  pwm_raw, pin_o, pin_oen, pin_lvl;
  logic [2:0]  cmps, out_mode;
  logic [1:0]  touts;
  int          bad_count, checks_done;
  always #2 pclk = ~pclk;
  ccs_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .triggered_mode_enable(trig_en), .single_shot_enable(one_en),
    .tb_rollover(pv[0]), .tb_tick(tick), .hw_trigger(hw_trig),
    .timer_mode(tmode), .mode_signal(msig), .cc_event(pv[1]),
    .cmp_event(pv[2]), .cap_overflow(pv[3]), .cap_not_empty(not_empty),
    .pwm_raw(pwm_raw), .capture_input_pin(cpin), .comparators(cmps),
    .logic_cells(cells), .fault_pin_a(fa), .fault_pin_b(fb),
    .timer_outs(touts), .pin_o(pin_o), .pin_oen(pin_oen),
    .aux_out(aux_out), .capture_src(capture_src),
    .capture_event(capture_event), .timer_hold(timer_hold),
    .out_mode(out_mode));
  ccs_far_model far_u (.sd_src(sd_src), .cap_src(cap_src), .pin_o(pin_o),
    .pin_oen(pin_oen), .fault_pin_a(fa), .fault_pin_b(fb),
    .timer_outs(touts), .comparators(cmps), .logic_cells(cells),
    .cap_pin(cpin), .pin_lvl(pin_lvl));
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      stop_test();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic wg(input logic [31:0] d);
    wr(ccs_pkg::ADDR_GATE_CTRL, d | ccs_pkg::RST_GATE_CTRL);
  endtask : wg
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic pls(input int k);
    @(posedge pclk);
    pv <= 4'h1 << k;
    @(posedge pclk);
    pv <= 4'h0;
  endtask : pls
  // Expects the shutdown flag to read as given
  task automatic sdf(input string nm, input logic [31:0] e);
    logic [31:0] r;
    rd(ccs_pkg::ADDR_STATUS, r);
    chk(nm, e, r & 32'h10);
  endtask : sdf
  task automatic t_regs;
    logic [31:0] r;
    rd(ccs_pkg::ADDR_GATE_CTRL, r);
    chk("gate_rst", ccs_pkg::RST_GATE_CTRL, r);
    rd(ccs_pkg::ADDR_PWM_CFG, r);
    chk("cfg_rst", 32'h0, r);
    wr(ccs_pkg::ADDR_PWM_CFG, 32'hffff_ffff);
    rd(ccs_pkg::ADDR_PWM_CFG, r);
    chk("cfg_mask", ccs_pkg::MASK_PWM_CFG, r);
    wr(ccs_pkg::ADDR_PWM_CFG, 32'h0);
    wr(ccs_pkg::ADDR_GATE_CTRL, 32'h0);
    cyc(4);
    chk("oen_off", 32'h3f, {26'h0, pin_oen});
    wr(ccs_pkg::ADDR_GATE_CTRL, 32'h8100_0000);
    cyc(4);
    chk("oen_wait", 32'h1, {31'h0, pin_oen[0]});
    pls(0);
    cyc(3);
    chk("oen_roll", 32'h0, {31'h0, pin_oen[0]});
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, r);
    chk("unmapped", 32'h1, {r[30:0], last_err});
    wg(32'h0);
  endtask : t_regs
  task automatic t_trig;
    logic [31:0] r;
    trig_en <= 1'b1;
    wr(ccs_pkg::ADDR_PWM_CFG, 32'h8000_0000);
    wr(ccs_pkg::ADDR_STATUS, 32'h20);
    cyc(4);
    chk("wait_pin", 32'h3, {30'h0, pin_oen[0], timer_hold});
    wr(ccs_pkg::ADDR_STATUS, 32'h40);
    rd(ccs_pkg::ADDR_STATUS, r);
    chk("trig_set", 32'h80, r & 32'h4e0);
    cyc(4);
    chk("run_pin", 32'h0, {30'h0, pin_oen[0], timer_hold});
    wr(ccs_pkg::ADDR_STATUS, 32'h420);
    rd(ccs_pkg::ADDR_STATUS, r);
    chk("trig_clr", 32'h0, r & 32'h4e0);
    wr(ccs_pkg::ADDR_PWM_CFG, 32'h0);
    trig_en <= 1'b0;
  endtask : t_trig
  task automatic t_flags;
    logic [31:0] r;
    not_empty <= 1'b1;
    pls(2);
    pls(3);
    rd(ccs_pkg::ADDR_STATUS, r);
    chk("flags_set", 32'hb, r & 32'hb);
    not_empty <= 1'b0;
    wr(ccs_pkg::ADDR_STATUS, 32'h0);
    rd(ccs_pkg::ADDR_STATUS, r);
    chk("flags_clr", 32'h0, r & 32'hb);
  endtask : t_flags
  task automatic t_shut;
    logic [31:0] pcv [4] = '{32'h8_0000, 32'hc_0000, 32'h0, 32'h28_0000};
    logic [2:0]  ex [4] = '{3'b100, 3'b101, 3'b110, 3'b001};
    for (int i = 0; i < 4; i++)
    begin
      wr(ccs_pkg::ADDR_PWM_CFG, pcv[i]);
      cyc(4);
      chk("pin_run", {31'h0, ex[i][2]}, {31'h0, pin_lvl[0]});
      wg(32'h1000);
      cyc(6);
      chk("pin_sd", 32'(ex[i][1:0]), 32'({pin_oen[0],pin_lvl[0]}));
      wg(32'h0);
      cyc(4);
      sdf("sd_held", 32'h10);
      wr(ccs_pkg::ADDR_STATUS, 32'h0);
      sdf("sd_clr", 32'h0);
    end
    wg(32'h5000);
    cyc(6);
    sdf("sd_wait", 32'h0);
    pls(0);
    cyc(4);
    sdf("sd_roll", 32'h10);
    wg(32'hc000);
    pls(0);
    cyc(4);
    sdf("sd_restart", 32'h0);
    wg(32'h0);
  endtask : t_shut
  task automatic t_src;
    for (int i = 0; i < 8; i++)
    begin
      sd_src <= 8'h1 << i;
      cyc(6);
      sdf("sd_masked", 32'h0);
      wg(32'h1 << i);
      cyc(6);
      sdf("sd_source", 32'h10);
      sd_src <= 8'h0;
      wg(32'h0);
      wr(ccs_pkg::ADDR_STATUS, 32'h0);
    end
  endtask : t_src
  task automatic t_cap;
    for (int i = 0; i < 8; i++)
    begin
      wg(32'(i) << ccs_pkg::GC_CSRC_LO);
      cap_src <= 8'h1 << i;
      cyc(6);
      chk("cap_hi", 32'h1, {31'h0, capture_src});
      cap_src <= ~(8'h1 << i);
      cyc(6);
      chk("cap_lo", 32'h0, {31'h0, capture_src});
      cap_src <= 8'h0;
    end
  endtask : t_cap
  task automatic t_aux;
    logic seen;
    for (int k = 0; k < 3; k++)
    begin
      tmode <= (k == 2);
      wg(k == 0 ? 32'h8_0000 : 32'h18_0000);
      pls(k > 0);
      seen = 1'b0;
      repeat (4)
      begin
        @(posedge pclk);
        seen = seen | aux_out;
      end
      chk("aux_out", {31'h0, k < 2}, {31'h0, seen});
    end
    tmode <= 1'b0;
    wg(32'h0);
  endtask : t_aux
  initial
  begin
    {presetn, psel, penable, pwrite, trig_en, one_en, tick, hw_trig} = '0;
    {tmode, msig, not_empty, paddr, sd_src, cap_src, pwdata, pv} = '0;
    pwm_raw = 6'h3f;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_trig();
    t_flags();
    t_shut();
    t_src();
    t_cap();
    t_aux();
    stop_test();
  end
endmodule : tb_top
